/* stm_brake_timer.sv */
`timescale 1ns/1ps
module stm_brake_timer
    import stm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Sequence
    input  wire logic       start,
    input  wire logic       running,
    input  wire logic       hold,
    input  wire logic       ms_tick,
    // Settings and speed
    input  wire logic [7:0] delay,
    input  wire logic       slow,
    output logic            engage_q
);
    logic       armed_q;
    logic [7:0] ms_cnt_q;
    wire        expired  = ms_cnt_q >= delay;
    wire        engage_d = hold && (engage_q || !armed_q || expired || slow);
    wire        count_up = hold && !engage_q && ms_tick && (ms_cnt_q != 8'hff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_q  <= 1'b0;
            ms_cnt_q <= 8'h00;
            engage_q <= 1'b0;
        end else begin
            armed_q  <= start ? running : armed_q;
            ms_cnt_q <= start ? 8'h00 : (count_up ? ms_cnt_q + 8'h01 : ms_cnt_q);
            engage_q <= engage_d; // [RULE11]
        end
    end

    brake_early_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        hold && (slow || expired) |=> engage_q || !hold)
        else $error("Brake not engaged at delay or low speed");

    brake_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        hold && armed_q && !slow && !expired && !engage_q |=> !engage_q)
        else $error("Brake engaged before delay or low speed");

endmodule : stm_brake_timer

/* stm_input_filter.sv */
`timescale 1ns/1ps
module stm_input_filter
    import stm_pkg::*;
#(
    parameter int CYCLES = FILTER_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Raw channel and qualified level
    input  wire logic raw,
    output logic      active_q
);
    localparam int CW = $clog2(CYCLES + 1);

    logic          sync1_q;
    logic          sync2_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] run_q;
    wire           differ = sync2_q != active_q;
    wire           flip   = differ && (cnt_q == CW'(CYCLES - 1));

    // Both directions need the full time, so a self-test low pulse never reaches the logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else begin
            sync1_q  <= raw;
            sync2_q  <= sync1_q;
            cnt_q    <= (differ && !flip) ? cnt_q + 1'b1 : '0; // [RULE15]
            active_q <= flip ? sync2_q : active_q;            // [RULE4]
        end
    end

    // Helper: consecutive low cycles of the synchronised input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= '0;
        end else begin
            run_q <= sync2_q ? '0 : ((run_q == CW'(CYCLES)) ? run_q : run_q + 1'b1);
        end
    end

    glitch_reject_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        $fell(active_q) |-> run_q == CW'(CYCLES))
        else $error("Channel dropped before the filter time");

endmodule : stm_input_filter

/* stm_pkg.sv */
// Function
// RULE1 - Input A inactive forces upper gates off
// RULE2 - Input B inactive forces lower gates off
// RULE3 - Either input inactive: torque off within 5 ms
// RULE4 - Inactive pulses under 1 ms are ignored
// RULE5 - Safety equipment holds deliberate requests over 5 ms
// RULE6 - Monitor high only when both inputs inactive
// RULE7 - Monitor follows inputs within 6 ms
// RULE8 - Safety equipment checks all four monitor combinations
// RULE9 - Restore inputs with servo-on off, else alarm
// RULE10 - Clear only after inputs return, else alarm
// RULE11 - Brake engages at delay or low speed
// RULE12 - Alarm state drives dynamic brake per alarm setting
// RULE13 - Restored servo-off uses servo-off stop setting
// RULE14 - Torque-off drops ready, alarms, shows error code
// RULE15 - Per-channel counter qualifies synchronised input levels
package stm_pkg;

    // Timing, in microseconds, and the clock rate
    localparam int CLK_FREQ_HZ     = 10000000;
    localparam int CLK_PER_US      = CLK_FREQ_HZ / 1000000;
    localparam int FILTER_TIME_US  = 1000;
    localparam int CUTOFF_TIME_US  = 5000;
    localparam int MONITOR_TIME_US = 6000;
    localparam int MS_TIME_US      = 1000;
    localparam int FILTER_CYCLES   = FILTER_TIME_US * CLK_PER_US;
    localparam int MS_CYCLES       = MS_TIME_US * CLK_PER_US;

    // Register byte offsets
    localparam logic [7:0] REG_BRAKE_DELAY   = 8'h00;
    localparam logic [7:0] REG_RELEASE_SPEED = 8'h04;
    localparam logic [7:0] REG_STOP_SEQ      = 8'h08;
    localparam logic [7:0] REG_STATUS        = 8'h0c;
    localparam logic [7:0] REG_INT_STATUS    = 8'h10;
    localparam logic [7:0] REG_INT_MASK      = 8'h14;

    // Field positions in the stop sequence register
    localparam int SEQ_ALARM_LSB = 0;
    localparam int SEQ_SOFF_LSB  = 4;

    // Interrupt bits
    localparam int INT_CUTOFF    = 0;
    localparam int INT_RESTORE   = 1;
    localparam int INT_SEQ_ALARM = 2;
    localparam int INT_EARLY_CLR = 3;
    localparam int INT_W         = 4;

    // Reset values
    localparam logic [7:0]       BRAKE_DELAY_RST   = 8'h32;
    localparam logic [15:0]      RELEASE_SPEED_RST = 16'h001e;
    localparam logic [1:0]       STOP_SEQ_RST      = 2'h0;
    localparam logic [INT_W-1:0] INT_MASK_RST      = 4'h0;

    // Display codes, values are arbitrary
    localparam logic [7:0] ERR_CODE_NONE   = 8'h00;
    localparam logic [7:0] ERR_CODE_CUTOFF = 8'h1e;

    typedef struct packed {
        logic [7:0]  brake_delay;
        logic [15:0] release_speed;
        logic [1:0]  alarm_seq;
        logic [1:0]  soff_seq;
    } stm_cfg_type;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_CUTOFF,
        ST_RESTORED
    } stm_state_type;

    // Bit 0 set: free run while moving; bit 1 set: release once stopped
    function automatic logic stm_db_engaged(input logic [1:0] seq, input logic moving);
        return moving ? ~seq[0] : ~seq[1];
    endfunction : stm_db_engaged

endpackage : stm_pkg

/* stm_safety_ctrl.sv */
`timescale 1ns/1ps
module stm_safety_ctrl #(
    parameter int HOLD   = 41,
    parameter int PULSE  = 6,
    parameter int SETTLE = 49
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Requests from the bench
    input  wire logic req_a,
    input  wire logic req_b,
    input  wire logic test_pulse,
    // Device side
    input  wire logic stop_state_monitor_out,
    output logic      safe_input_a,
    output logic      safe_input_b,
    output logic      mon_err
);
    logic [7:0] hold_a_q, hold_b_q, pulse_q, settle_q;
    logic       a_q, b_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_a_q     <= 8'h00;
            hold_b_q     <= 8'h00;
            pulse_q      <= 8'h00;
            settle_q     <= 8'h00;
            safe_input_a <= 1'b1;
            safe_input_b <= 1'b1;
            a_q          <= 1'b1;
            b_q          <= 1'b1;
            mon_err      <= 1'b0;
        end else begin
            // A deliberate request stays low for the whole hold time
            hold_a_q <= (hold_a_q != 8'h00) ? hold_a_q - 8'h01 : ((!req_a && safe_input_a) ? 8'(HOLD) : 8'h00);
            hold_b_q <= (hold_b_q != 8'h00) ? hold_b_q - 8'h01 : ((!req_b && safe_input_b) ? 8'(HOLD) : 8'h00);
            // Self-test low pulse, shorter than the filter
            pulse_q <= test_pulse ? 8'(PULSE) : ((pulse_q != 8'h00) ? pulse_q - 8'h01 : 8'h00);
            safe_input_a <= req_a & (hold_a_q == 8'h00) & (pulse_q == 8'h00);
            safe_input_b <= req_b & (hold_b_q == 8'h00);
            a_q <= safe_input_a;
            b_q <= safe_input_b;
            // Judge the monitor once each input pair has settled
            settle_q <= (a_q != safe_input_a || b_q != safe_input_b) ? 8'h00 :
                        ((settle_q < 8'(SETTLE)) ? settle_q + 8'h01 : settle_q);
            if (settle_q == 8'(SETTLE - 1) && stop_state_monitor_out !== (~a_q & ~b_q)) begin
                mon_err <= 1'b1;
            end
        end
    end
endmodule : stm_safety_ctrl

/* stm_torque_monitor.sv */
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module stm_torque_monitor
    import stm_pkg::*;
#(
    parameter int FILT_CYCLES = FILTER_CYCLES,
    parameter int TICK_CYCLES = MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Safety inputs, high while energised
    input  wire logic        safe_input_a,
    input  wire logic        safe_input_b,
    // Drive sequence
    input  wire logic        servo_on_in,
    input  wire logic        alarm_clear_in,
    input  wire logic [15:0] motor_speed,
    // Power stage and brakes
    output logic             gate_upper_en,
    output logic             gate_lower_en,
    output logic             torque_cutoff,
    output logic             brake_engage,
    output logic             dyn_brake,
    // Status towards safety equipment and panel
    output logic             stop_state_monitor_out,
    output logic             servo_ready,
    output logic             alarm_out,
    output logic [7:0]       error_code,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rd_data,
    // Interrupt
    output logic             irq
);
    localparam int TW        = $clog2(TICK_CYCLES + 1);
    localparam int OFF_LIMIT = FILT_CYCLES * CUTOFF_TIME_US / FILTER_TIME_US;
    localparam int MON_LIMIT = FILT_CYCLES * MONITOR_TIME_US / FILTER_TIME_US;

    stm_state_type    state_q;
    stm_state_type    state_d;
    stm_cfg_type      cfg_q;
    logic [INT_W-1:0] int_stat_q;
    logic [INT_W-1:0] int_mask_q;
    logic [TW-1:0]    tick_cnt_q;
    logic             clr_prev_q;
    logic             seq_alarm_q;
    logic             gate_upper_q;
    logic             gate_lower_q;
    logic             cutoff_q;
    logic             brake_q;
    logic             dyn_brake_q;
    logic             monitor_q;
    logic             ready_q;
    logic             alarm_q;
    logic [7:0]       err_q;
    logic [31:0]      rd_data_q;
    logic             irq_q;
    logic             filt_a;
    logic             filt_b;
    logic             brk_engage;

    // Qualified channels
    stm_input_filter #(
        .CYCLES   (FILT_CYCLES)
    ) u_filt_a (
        .clk      (clk),
        .rst_n    (rst_n),
        .raw      (safe_input_a),
        .active_q (filt_a)
    );

    stm_input_filter #(
        .CYCLES   (FILT_CYCLES)
    ) u_filt_b (
        .clk      (clk),
        .rst_n    (rst_n),
        .raw      (safe_input_b),
        .active_q (filt_b)
    );

    // Decoding
    wire both_on    = filt_a && filt_b;
    wire clr_rise   = alarm_clear_in && !clr_prev_q;
    wire ms_tick    = tick_cnt_q == TW'(TICK_CYCLES - 1);
    wire moving     = motor_speed != 16'h0000;
    wire slow       = motor_speed < cfg_q.release_speed;
    wire enter_cut  = (state_q == ST_NORMAL) && !both_on;
    wire restore    = (state_q == ST_CUTOFF) && both_on;
    wire early_clr  = (state_q == ST_CUTOFF) && clr_rise;
    wire good_clr   = (state_q == ST_RESTORED) && both_on && clr_rise;
    wire seq_fault  = restore && servo_on_in;
    wire alarm_d    = state_d != ST_NORMAL;
    wire hit_brake  = wr_en && (addr == REG_BRAKE_DELAY);
    wire hit_speed  = wr_en && (addr == REG_RELEASE_SPEED);
    wire hit_seq    = wr_en && (addr == REG_STOP_SEQ);
    wire hit_istat  = wr_en && (addr == REG_INT_STATUS);
    wire hit_imask  = wr_en && (addr == REG_INT_MASK);

    // Events for the sticky status bits
    wire [INT_W-1:0] events = {early_clr, seq_fault, restore, enter_cut};

    // Any alarm state removes torque; clear is only honoured once both channels are back
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL: begin
                if (!both_on) begin
                    state_d = ST_CUTOFF;                       // [RULE3] [RULE14]
                end
            end
            ST_CUTOFF: begin
                if (both_on) begin
                    state_d = ST_RESTORED;
                end
            end
            ST_RESTORED: begin
                if (!both_on) begin
                    state_d = ST_CUTOFF;
                end else if (clr_rise) begin
                    state_d = ST_NORMAL;                       // [RULE10]
                end
            end
            default: begin
                state_d = ST_CUTOFF;
            end
        endcase
    end

    // Gate drive per half bridge, forced off by its own channel
    wire gate_upper_d = filt_a && !alarm_d && servo_on_in;    // [RULE1]
    wire gate_lower_d = filt_b && !alarm_d && servo_on_in;    // [RULE2]
    wire monitor_d    = !filt_a && !filt_b;                   // [RULE6] [RULE7]

    // Dynamic brake: alarm setting in alarm, servo-off setting when servo is off
    wire db_alarm  = stm_db_engaged(cfg_q.alarm_seq, moving); // [RULE12]
    wire db_soff   = stm_db_engaged(cfg_q.soff_seq, moving);  // [RULE13]
    wire dyn_d     = alarm_d ? db_alarm : (!servo_on_in && db_soff);
    wire brake_d   = alarm_d ? brk_engage : !servo_on_in;
    wire [7:0] err_d = alarm_d ? ERR_CODE_CUTOFF : ERR_CODE_NONE;

    stm_brake_timer u_brake (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (enter_cut),
        .running  (servo_on_in),
        .hold     (state_q != ST_NORMAL),
        .ms_tick  (ms_tick),
        .delay    (cfg_q.brake_delay),
        .slow     (slow),
        .engage_q (brk_engage)
    );

    // Sequence state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= ST_NORMAL;
            clr_prev_q  <= 1'b0;
            seq_alarm_q <= 1'b0;
            tick_cnt_q  <= '0;
        end else begin
            state_q     <= state_d;
            clr_prev_q  <= alarm_clear_in;
            seq_alarm_q <= seq_fault || (seq_alarm_q && !good_clr); // [RULE9]
            tick_cnt_q  <= ms_tick ? '0 : tick_cnt_q + 1'b1;
        end
    end

    // Output flops; reset state is torque off until the channels qualify and an alarm clear follows
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gate_upper_q <= 1'b0;
            gate_lower_q <= 1'b0;
            cutoff_q     <= 1'b1;
            brake_q      <= 1'b1;
            dyn_brake_q  <= 1'b1;
            monitor_q    <= 1'b0;
            ready_q      <= 1'b0;
            alarm_q      <= 1'b1;
            err_q        <= ERR_CODE_CUTOFF;
        end else begin
            gate_upper_q <= gate_upper_d;
            gate_lower_q <= gate_lower_d;
            cutoff_q     <= alarm_d;
            brake_q      <= brake_d;      // [RULE11]
            dyn_brake_q  <= dyn_d;
            monitor_q    <= monitor_d;
            ready_q      <= !alarm_d;     // [RULE14]
            alarm_q      <= alarm_d || seq_fault;
            err_q        <= err_d;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q.brake_delay   <= BRAKE_DELAY_RST;
            cfg_q.release_speed <= RELEASE_SPEED_RST;
            cfg_q.alarm_seq     <= STOP_SEQ_RST;
            cfg_q.soff_seq      <= STOP_SEQ_RST;
            int_mask_q          <= INT_MASK_RST;
        end else begin
            if (hit_brake) begin
                cfg_q.brake_delay <= wr_data[7:0];
            end
            if (hit_speed) begin
                cfg_q.release_speed <= wr_data[15:0];
            end
            if (hit_seq) begin
                cfg_q.alarm_seq <= wr_data[SEQ_ALARM_LSB+:2];
                cfg_q.soff_seq  <= wr_data[SEQ_SOFF_LSB+:2];
            end
            if (hit_imask) begin
                int_mask_q <= wr_data[INT_W-1:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    wire [INT_W-1:0] w1c = hit_istat ? wr_data[INT_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~w1c) | events;
            irq_q      <= |(((int_stat_q & ~w1c) | events) & int_mask_q);
        end
    end

    // Read mux, data in the cycle after the strobe only
    wire [7:0] status_word = {seq_alarm_q, dyn_brake_q, brake_q, monitor_q, filt_b, filt_a, state_q};
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            REG_BRAKE_DELAY:   rd_mux = {24'h000000, cfg_q.brake_delay};
            REG_RELEASE_SPEED: rd_mux = {16'h0000, cfg_q.release_speed};
            REG_STOP_SEQ:      rd_mux = {26'h0000000, cfg_q.soff_seq, 2'h0, cfg_q.alarm_seq};
            REG_STATUS:        rd_mux = {24'h000000, status_word};
            REG_INT_STATUS:    rd_mux = {28'h0000000, int_stat_q};
            REG_INT_MASK:      rd_mux = {28'h0000000, int_mask_q};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= 32'h0000_0000;
        end else begin
            rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    assign gate_upper_en          = gate_upper_q;
    assign gate_lower_en          = gate_lower_q;
    assign torque_cutoff          = cutoff_q;
    assign brake_engage           = brake_q;
    assign dyn_brake              = dyn_brake_q;
    assign stop_state_monitor_out = monitor_q;
    assign servo_ready            = ready_q;
    assign alarm_out              = alarm_q;
    assign error_code             = err_q;
    assign rd_data                = rd_data_q;
    assign irq                    = irq_q;

    // Helper counters for the timing checks
    int unsigned off_a_q;
    int unsigned off_b_q;
    int unsigned stab_q;
    logic        raw_a_q;
    logic        raw_b_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            off_a_q <= 0;
            off_b_q <= 0;
            stab_q  <= 0;
            raw_a_q <= 1'b0;
            raw_b_q <= 1'b0;
        end else begin
            off_a_q <= safe_input_a ? 0 : ((off_a_q < OFF_LIMIT) ? off_a_q + 1 : off_a_q);
            off_b_q <= safe_input_b ? 0 : ((off_b_q < OFF_LIMIT) ? off_b_q + 1 : off_b_q);
            raw_a_q <= safe_input_a;
            raw_b_q <= safe_input_b;
            if ((safe_input_a != raw_a_q) || (safe_input_b != raw_b_q)) begin
                stab_q <= 0;
            end else if (stab_q < MON_LIMIT) begin
                stab_q <= stab_q + 1;
            end
        end
    end

    upper_gate_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        !filt_a |=> !gate_upper_en)
        else $error("Upper gate driven with channel A inactive");

    lower_gate_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        !filt_b |=> !gate_lower_en)
        else $error("Lower gate driven with channel B inactive");

    cutoff_in_time_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        (off_a_q >= OFF_LIMIT || off_b_q >= OFF_LIMIT) |-> torque_cutoff && !gate_upper_en && !gate_lower_en)
        else $error("Torque not removed within the cutoff time");

    monitor_only_both_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        (filt_a || filt_b) |=> !stop_state_monitor_out)
        else $error("Monitor high with a channel active");

    monitor_delay_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        stab_q >= MON_LIMIT |-> stop_state_monitor_out == (!raw_a_q && !raw_b_q))
        else $error("Monitor late against inputs");

    seq_alarm_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        seq_fault |=> seq_alarm_q && int_stat_q[INT_SEQ_ALARM] && alarm_out)
        else $error("Return under servo-on raised no alarm");

    early_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        early_clr |=> (state_q != ST_NORMAL) && int_stat_q[INT_EARLY_CLR] ##1 !servo_ready)
        else $error("Early clear left the alarm");

    alarm_db_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        torque_cutoff && ($past(cfg_q.alarm_seq) == 2'h0) |-> dyn_brake)
        else $error("Dynamic brake off under alarm setting");

    servo_off_db_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        !torque_cutoff && !$past(servo_on_in) && ($past(cfg_q.soff_seq) == 2'h3) |-> !dyn_brake)
        else $error("Dynamic brake against servo-off setting");

    ready_error_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
        torque_cutoff |-> !servo_ready && alarm_out && (error_code == ERR_CODE_CUTOFF))
        else $error("Torque-off without alarm indication");

    cutoff_entry_c: cover property (@(posedge clk) disable iff (!rst_n)
        state_q == ST_NORMAL ##1 state_q == ST_CUTOFF);

    restore_servo_on_c: cover property (@(posedge clk) disable iff (!rst_n)
        seq_fault);

    clear_to_normal_c: cover property (@(posedge clk) disable iff (!rst_n)
        good_clr ##1 state_q == ST_NORMAL);

    monitor_high_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(stop_state_monitor_out));

endmodule : stm_torque_monitor

/* tb_stm_torque_monitor.sv */
`timescale 1ns/1ps
module tb_stm_torque_monitor;
    import stm_pkg::*;
    localparam int F   = 8;
    localparam int CUT = 5 * F;
    localparam int MON = 6 * F;
    logic clk = 1'b0, rst_n = 1'b0, req_a = 1'b1, req_b = 1'b1, tp = 1'b0, rd_seen = 1'b0;
    logic servo_on_in = 1'b0, alarm_clear_in = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [15:0] motor_speed = 16'h0000;
    logic [7:0]  addr = 8'h00, error_code;
    logic [31:0] wr_data = 32'h0, rd_data, rnd;
    logic safe_input_a, safe_input_b, gate_upper_en, gate_lower_en, torque_cutoff, brake_engage;
    logic dyn_brake, stop_state_monitor_out, servo_ready, alarm_out, irq, mon_err;
    logic [31:0] exp_q[$];
    int mismatches = 0, tests_run = 0, seed = 32'h38a13610;

    always #50 clk = ~clk;

    stm_safety_ctrl #(.HOLD(CUT + 1), .PULSE(F - 2), .SETTLE(MON - 2)) ctl_u (.clk, .rst_n, .req_a, .req_b,
        .test_pulse(tp), .stop_state_monitor_out, .safe_input_a, .safe_input_b, .mon_err);
    stm_torque_monitor #(.FILT_CYCLES(F), .TICK_CYCLES(4)) dut_u (.clk, .rst_n, .safe_input_a, .safe_input_b,
        .servo_on_in, .alarm_clear_in, .motor_speed, .gate_upper_en, .gate_lower_en, .torque_cutoff,
        .brake_engage, .dyn_brake, .stop_state_monitor_out, .servo_ready, .alarm_out, .error_code,
        .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    task automatic clr();
        @(posedge clk) alarm_clear_in <= 1'b1;
        @(posedge clk) alarm_clear_in <= 1'b0;
    endtask : clr

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_en;
    always @(negedge clk) begin
        if (rd_seen) begin
            chk("rd_data", exp_q.pop_front(), rd_data);
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_BRAKE_DELAY, {24'h0, BRAKE_DELAY_RST});
        rd(REG_RELEASE_SPEED, {16'h0, RELEASE_SPEED_RST});
        rd(REG_INT_MASK, 32'h0);
        rd(8'h40, 32'h0);
        $display("test reset done");
        wt(CUT);
        clr();
        @(posedge clk) servo_on_in <= 1'b1;
        wt(3);
        chk("servo_ready", 1, servo_ready);
        @(posedge clk) tp <= 1'b1;
        @(posedge clk) tp <= 1'b0;
        wt(CUT);
        chk("torque_cutoff", 0, torque_cutoff);
        chk("gate_upper_en", 1, gate_upper_en);
        $display("test filter done");
        wr(REG_INT_STATUS, 32'hf);
        wr(REG_INT_MASK, 32'h1);
        wr(REG_BRAKE_DELAY, 32'hff);
        rnd = $random(seed);
        @(posedge clk) motor_speed <= {1'b0, rnd[14:8], 8'h80};
        @(posedge clk) req_a <= 1'b0;
        wt(CUT);
        chk("gate_upper_en", 0, gate_upper_en);
        chk("torque_cutoff", 1, torque_cutoff);
        chk("servo_ready", 0, servo_ready);
        chk("alarm_out", 1, alarm_out);
        chk("error_code", ERR_CODE_CUTOFF, error_code);
        chk("irq", 1, irq);
        chk("monitor", 0, stop_state_monitor_out);
        chk("dyn_brake", 1, dyn_brake);
        chk("brake_engage", 0, brake_engage);
        @(posedge clk) motor_speed <= 16'h0000;
        wt(4);
        chk("brake_engage", 1, brake_engage);
        wr(REG_INT_STATUS, 32'h1);
        wt(2);
        chk("irq", 0, irq);
        $display("test cutoff done");
        clr();
        wt(2);
        chk("torque_cutoff", 1, torque_cutoff);
        rd(REG_INT_STATUS, 32'h8);
        wr(REG_INT_STATUS, 32'hf);
        @(posedge clk) req_a <= 1'b1;
        wt(CUT);
        chk("torque_cutoff", 1, torque_cutoff);
        rd(REG_INT_STATUS, 32'h6);
        @(posedge clk) servo_on_in <= 1'b0;
        clr();
        wt(3);
        chk("servo_ready", 1, servo_ready);
        wr(REG_STOP_SEQ, 32'h10);
        @(posedge clk) motor_speed <= 16'h0200;
        wt(3);
        chk("dyn_brake", 0, dyn_brake);
        $display("test restore done");
        wr(REG_STOP_SEQ, 32'h1);
        wr(REG_BRAKE_DELAY, 32'h2);
        @(posedge clk) servo_on_in <= 1'b1;
        @(posedge clk) req_b <= 1'b0;
        wt(CUT);
        chk("gate_lower_en", 0, gate_lower_en);
        chk("dyn_brake", 0, dyn_brake);
        chk("brake_engage", 1, brake_engage);
        $display("test channel b done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) req_a <= i[1];
            req_b <= i[0];
            wt(MON);
            chk("monitor", (i == 0), stop_state_monitor_out);
        end
        chk("mon_err", 0, mon_err);
        $display("test monitor done");
        stop_test();
    end

    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : tb_stm_torque_monitor
